// ---- hdl/sksr_port.sv ----
// Serial slave port with ready handshake and command responses.
`timescale 1ns/10ps
`include "sksr_cfg.svh"
// Functional notes
// RQ1: Slave only; bytes move on host clocks
// RQ2: Every command answered; status carries check byte (code answers unknown codes with null, sets comm error)
// RQ3: Host resyncs with last-command query until complement
// RQ4: Host polls no faster than 10 ms
// RQ5: Host uses first-key command in run
// RQ6: Ready open-drain, high idle, low busy
// RQ7: Ready drops after each received byte
// RQ8: Ready goes low within 40 us
// RQ9: Eeprom and setups commands release within 25 ms
// RQ10: Others release within 2 ms / 40 us
// RQ11: Low pulse 1 us; after reset 1 ms
// RQ12: Clock idles high; out falling, in rising
// RQ13: Host frames bytes with slave select low
// RQ14: Data output floats while select high
// RQ15: Host clocks nulls to fetch responses
// RQ16: Commands during intermediate response bytes ignored
// RQ17: Unknown command: release ready, set comm error
// RQ18: 100 ms byte gap abandons command silently
// RQ19: Multi-byte values least significant byte first
// RQ20: Byte is eight bits, MSB first
module sksr_port
#(
	parameter int RESET_LOW_CYC = `SKSR_T_RESET_LOW_US * `SKSR_CLK_MHZ,
	parameter int LONG_BUSY_CYC = `SKSR_T_LONG_BUSY_MS * 1000 * `SKSR_CLK_MHZ,
	parameter int BYTE_TIMEOUT_CYC = `SKSR_T_BYTE_TIMEOUT_MS * 1000 * `SKSR_CLK_MHZ
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Serial pins
	input wire logic sck,
	input wire logic ssN,
	input wire logic mosi,
	output logic misoOut,
	output logic misoOeN,
	// Ready handshake pin, open drain
	input wire logic transferReadyIn,
	output logic transferReadyOut,
	output logic transferReadyOeN,
	// Sensing engine state
	input wire logic [7:0] sensorStatus,
	input wire logic [7:0] firstKeyReport,
	// Last command seen, for the sensing engine
	output logic [7:0] lastCommand
);
	localparam int LOW_MIN_CYC = (`SKSR_T_READY_LOW_MIN_NS * `SKSR_CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 24;

	function automatic logic [7:0] crc8Step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++)
		begin
			c = c[7] ? ({c[6:0], 1'b0} ^ `SKSR_CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	logic [7:0] rxByte, txByte;
	logic rxValid;
	sksr_pkg::ready_state_e readyStateReg, readyStateNext;
	logic [CNT_W-1:0] busyCntReg, busyCntNext, gapCntReg, gapCntNext;
	logic [7:0] resp0Reg, resp0Next, resp1Reg, resp1Next;
	logic [1:0] respCntReg, respCntNext;
	logic [7:0] lastCmdReg, lastCmdNext;
	logic commErrReg, commErrNext, readyOeNReg, readyOeNNext;
	logic [7:0] statusByte;
	logic intermediate;

	sksr_spi_byte u_byte
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.sck(sck),
		.ssN(ssN),
		.mosi(mosi),
		.misoOut(misoOut),
		.misoOeN(misoOeN),
		.txByte(txByte),
		.rxByte(rxByte),
		.rxValid(rxValid)
	);

	// Idle output carries zero bytes; responses only leave on host clocks
	assign txByte = (respCntReg != 2'd0) ? resp0Reg : `SKSR_CMD_NULL; // see RQ1 see RQ15
	assign statusByte = {sensorStatus[7], commErrReg, sensorStatus[5:0]};
	assign intermediate = respCntReg > 2'd1;

	always_comb
	begin
		readyStateNext = readyStateReg;
		busyCntNext = busyCntReg;
		gapCntNext = gapCntReg;
		resp0Next = resp0Reg;
		resp1Next = resp1Reg;
		respCntNext = respCntReg;
		lastCmdNext = lastCmdReg;
		commErrNext = commErrReg;
		unique case (readyStateReg)
			sksr_pkg::RDY_RESET:
			begin
				if (busyCntReg == CNT_W'(RESET_LOW_CYC - 1)) // see RQ11
				begin
					readyStateNext = sksr_pkg::RDY_IDLE;
				end
				else
				begin
					busyCntNext = busyCntReg + 1'b1;
				end
			end
			sksr_pkg::RDY_IDLE:
			begin
				busyCntNext = '0;
			end
			sksr_pkg::RDY_BUSY:
			begin
				if (busyCntReg == '0)
				begin
					readyStateNext = sksr_pkg::RDY_IDLE;
				end
				else
				begin
					busyCntNext = busyCntReg - 1'b1;
				end
			end
		endcase
		// Pending answer dropped after a long byte gap
		if (respCntReg == 2'd0 || rxValid)
		begin
			gapCntNext = '0;
		end
		else if (gapCntReg == CNT_W'(BYTE_TIMEOUT_CYC - 1))
		begin
			respCntNext = 2'd0; // see RQ18
			gapCntNext = '0;
		end
		else
		begin
			gapCntNext = gapCntReg + 1'b1;
		end
		if (rxValid && readyStateReg != sksr_pkg::RDY_RESET)
		begin
			// Each byte pulls ready low for at least the minimum
			readyStateNext = sksr_pkg::RDY_BUSY; // see RQ7 see RQ8
			busyCntNext = CNT_W'(LOW_MIN_CYC - 1); // see RQ10 see RQ11
			if (respCntReg != 2'd0)
			begin
				resp0Next = resp1Reg;
				respCntNext = respCntReg - 2'd1;
			end
			if (!intermediate && rxByte != `SKSR_CMD_NULL) // see RQ16
			begin
				lastCmdNext = rxByte;
				respCntNext = 2'd1; // see RQ2
				unique case (rxByte)
					`SKSR_CMD_LAST:
					begin
						resp0Next = ~lastCmdReg; // see RQ3
						if (lastCmdReg == `SKSR_CMD_LAST)
						begin
							commErrNext = 1'b0;
						end
					end
					`SKSR_CMD_STATUS:
					begin
						// Check byte folds in the command code first
						resp0Next = statusByte; // see RQ19
						resp1Next = crc8Step(crc8Step(`SKSR_CRC_INIT, rxByte), statusByte);
						respCntNext = 2'd2; // see RQ2
					end
					`SKSR_CMD_FIRST_KEY:
					begin
						resp0Next = firstKeyReport;
						resp0Next[`SKSR_STAT_ANY_ERR] = firstKeyReport[`SKSR_STAT_ANY_ERR]
							| commErrReg;
					end
					`SKSR_CMD_EEPROM_CRC, `SKSR_CMD_SETUPS:
					begin
						resp0Next = (rxByte == `SKSR_CMD_SETUPS) ? `SKSR_RESP_SETUPS
							: `SKSR_CRC_INIT;
						busyCntNext = CNT_W'(LONG_BUSY_CYC - 1); // see RQ9
					end
					default:
					begin
						// Unknown code: short low pulse, then release
						respCntNext = 2'd0;
						commErrNext = 1'b1; // see RQ17
					end
				endcase
			end
		end
		readyOeNNext = readyStateNext == sksr_pkg::RDY_IDLE; // see RQ6
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			readyStateReg <= sksr_pkg::RDY_RESET;
			busyCntReg <= '0;
			gapCntReg <= '0;
			resp0Reg <= 8'h00;
			resp1Reg <= 8'h00;
			respCntReg <= 2'd0;
			lastCmdReg <= 8'h00;
			commErrReg <= 1'b0;
			readyOeNReg <= 1'b0;
		end
		else
		begin
			readyStateReg <= readyStateNext;
			busyCntReg <= busyCntNext;
			gapCntReg <= gapCntNext;
			resp0Reg <= resp0Next;
			resp1Reg <= resp1Next;
			respCntReg <= respCntNext;
			lastCmdReg <= lastCmdNext;
			commErrReg <= commErrNext;
			readyOeNReg <= readyOeNNext;
		end
	end

	// Open drain: only ever pulls low
	logic readyOutReg;
	always_ff @(posedge clk_sys)
	begin
		readyOutReg <= 1'b0;
	end

	assign transferReadyOut = readyOutReg;
	assign transferReadyOeN = readyOeNReg;
	assign lastCommand = lastCmdReg;
endmodule // sksr_port

// ---- hdl/sksr_spi_byte.sv ----
// Byte shifter of the serial port, sampled by the system clock.
`timescale 1ns/10ps
module sksr_spi_byte
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Serial pins
	input wire logic sck,
	input wire logic ssN,
	input wire logic mosi,
	output logic misoOut,
	output logic misoOeN,
	// Byte side
	input wire logic [7:0] txByte,
	output logic [7:0] rxByte,
	output logic rxValid
);
	logic [2:0] sckSyncReg, ssSyncReg, sckSyncNext, ssSyncNext;
	logic [1:0] mosiSyncReg, mosiSyncNext;
	logic [7:0] txShiftReg, txShiftNext, rxShiftReg, rxShiftNext;
	logic [7:0] rxByteReg, rxByteNext;
	logic [3:0] bitCntReg, bitCntNext;
	logic rxValidReg, rxValidNext, misoReg, misoNext, oeNReg, oeNNext;
	logic sckRise, sckFall, ssFall, ssLow;

	// Stage 0 feeds stage 1 only; edges come from stages 1 and 2
	assign sckRise = sckSyncReg[1] & ~sckSyncReg[2];
	assign sckFall = ~sckSyncReg[1] & sckSyncReg[2];
	assign ssFall = ~ssSyncReg[1] & ssSyncReg[2];
	assign ssLow = ~ssSyncReg[1];

	always_comb
	begin
		sckSyncNext = {sckSyncReg[1:0], sck};
		ssSyncNext = {ssSyncReg[1:0], ssN};
		mosiSyncNext = {mosiSyncReg[0], mosi};
		txShiftNext = txShiftReg;
		rxShiftNext = rxShiftReg;
		rxByteNext = rxByteReg;
		bitCntNext = bitCntReg;
		rxValidNext = 1'b0;
		misoNext = misoReg;
		oeNNext = ~ssLow; // see RQ14
		if (ssFall)
		begin
			txShiftNext = txByte;
			bitCntNext = 4'h0;
		end
		else if (ssLow)
		begin
			if (sckFall)
			begin
				misoNext = txShiftReg[7]; // see RQ12 see RQ20
				txShiftNext = {txShiftReg[6:0], 1'b0};
			end
			if (sckRise && bitCntReg < 4'h8)
			begin
				rxShiftNext = {rxShiftReg[6:0], mosiSyncReg[1]}; // see RQ12
				bitCntNext = bitCntReg + 4'h1;
				if (bitCntReg == 4'h7)
				begin
					rxByteNext = {rxShiftReg[6:0], mosiSyncReg[1]}; // see RQ20
					rxValidNext = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sckSyncReg <= 3'h7;
			ssSyncReg <= 3'h7;
			mosiSyncReg <= 2'h0;
			txShiftReg <= 8'h00;
			rxShiftReg <= 8'h00;
			rxByteReg <= 8'h00;
			bitCntReg <= 4'h0;
			rxValidReg <= 1'b0;
			misoReg <= 1'b0;
			oeNReg <= 1'b1;
		end
		else
		begin
			sckSyncReg <= sckSyncNext;
			ssSyncReg <= ssSyncNext;
			mosiSyncReg <= mosiSyncNext;
			txShiftReg <= txShiftNext;
			rxShiftReg <= rxShiftNext;
			rxByteReg <= rxByteNext;
			bitCntReg <= bitCntNext;
			rxValidReg <= rxValidNext;
			misoReg <= misoNext;
			oeNReg <= oeNNext;
		end
	end

	assign misoOut = misoReg;
	assign misoOeN = oeNReg;
	assign rxByte = rxByteReg;
	assign rxValid = rxValidReg;
endmodule // sksr_spi_byte

// ---- pkg/sksr_cfg.svh ----
// Constants of the serial key sensor port: codes, bit positions, times.
`ifndef SKSR_CFG_SVH
`define SKSR_CFG_SVH

`define SKSR_CLK_MHZ 125
`define SKSR_BYTE_W 8

`define SKSR_CMD_NULL 8'h00
`define SKSR_CMD_SETUPS 8'h01
`define SKSR_CMD_STATUS 8'h05
`define SKSR_CMD_FIRST_KEY 8'h06
`define SKSR_CMD_EEPROM_CRC 8'h0E
`define SKSR_CMD_LAST 8'h0F

`define SKSR_RESP_SETUPS 8'hFE
`define SKSR_RESP_NO_KEY 8'h1F
`define SKSR_CRC_POLY 8'h07
`define SKSR_CRC_INIT 8'h00

`define SKSR_STAT_COMM_ERR 6
`define SKSR_STAT_ANY_ERR 6
`define SKSR_STAT_FMEA 5
`define SKSR_STAT_CAL_FAIL 2

`define SKSR_T_READY_LOW_MIN_NS 1000
`define SKSR_T_RESET_LOW_US 1000
`define SKSR_T_LONG_BUSY_MS 20
`define SKSR_T_BYTE_TIMEOUT_MS 100

`endif

// ---- pkg/sksr_pkg.sv ----
// Types of the serial key sensor port.
package sksr_pkg;
	typedef enum logic [1:0] {
		RDY_RESET,
		RDY_IDLE,
		RDY_BUSY
	} ready_state_e;

	typedef logic [7:0] byte_t;
endpackage

// ---- test/sksr_host_model.sv ----
// Host master model that paces bytes on the ready line.
`timescale 1ns/10ps
module sksr_host_model
(
	// Clock
	input wire logic clk_sys,
	// Serial pins
	output logic sck,
	output logic ssN,
	output logic mosi,
	input wire logic miso,
	input wire logic misoOeN,
	// Ready wire
	input wire logic rdy
);
	initial
	begin
		sck = 1'b1;
		ssN = 1'b1;
		mosi = 1'b0;
	end

	task automatic half();
		repeat (5) @(negedge clk_sys);
	endtask

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		while (rdy !== 1'b1 && n < 1000)
		begin
			@(negedge clk_sys);
			n++;
		end
		ssN = 1'b0;
		half();
		for (int i = 7; i >= 0; i--)
		begin
			sck = 1'b0;
			mosi = tx[i];
			half();
			rx[i] = misoOeN ? 1'bx : miso;
			sck = 1'b1;
			half();
		end
		ssN = 1'b1;
		mosi = ~mosi;
		// Drop of ready must show inside the wait
		for (int k = 0; k < 5000; k++)
		begin
			@(negedge clk_sys);
			ok = ok | (rdy === 1'b0);
		end
		ok = ok && (n < 1000);
	endtask
endmodule // sksr_host_model

// ---- test/sksr_port_asserts.sv ----
// Pin assertions of the serial key port.
`timescale 1ns/10ps
module sksr_port_asserts
#(
	parameter int RESET_LOW_CYC = 200,
	parameter int LONG_BUSY_CYC = 300
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Serial pins
	input wire logic sck,
	input wire logic ssN,
	input wire logic misoOut,
	input wire logic misoOeN,
	// Ready pin
	input wire logic transferReadyOut,
	input wire logic transferReadyOeN
);
	int lowCnt_reg;
	int lowCnt_next;
	logic upSeen_reg;
	logic upSeen_next;

	// Low time of ready, first release after reset
	always_comb
	begin
		lowCnt_next = transferReadyOeN ? 0 : lowCnt_reg + 1;
		upSeen_next = upSeen_reg | transferReadyOeN;
		if (rst)
		begin
			lowCnt_next = 0;
			upSeen_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		lowCnt_reg <= lowCnt_next;
		upSeen_reg <= upSeen_next;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_ready_open_drain: assert property (!transferReadyOut)
		else $error("ready driven high");
	a_low_min_width: assert property ($rose(transferReadyOeN) |-> lowCnt_reg >= 125)
		else $error("ready low too short");
	a_reset_low_time: assert property ($rose(transferReadyOeN) && !upSeen_reg
		|-> lowCnt_reg >= RESET_LOW_CYC) else $error("reset low too short");
	a_release_bound: assert property (lowCnt_reg <= RESET_LOW_CYC + LONG_BUSY_CYC)
		else $error("ready held low too long");
	a_byte_ready_drop: assert property ($rose(ssN) |-> ##[0:100] !transferReadyOeN)
		else $error("ready did not drop");
	a_miso_float: assert property (ssN [*4] |-> misoOeN)
		else $error("miso driven while deselected");
	a_miso_drive: assert property (!ssN [*4] |-> !misoOeN)
		else $error("miso not driven while selected");
	a_miso_steady: assert property ($rose(sck) && !ssN |-> ##1 $stable(misoOut) [*3])
		else $error("miso moved near rising clock");
endmodule // sksr_port_asserts

bind sksr_port sksr_port_asserts #(
	.RESET_LOW_CYC(RESET_LOW_CYC),
	.LONG_BUSY_CYC(LONG_BUSY_CYC)
) u_chk (
	.clk_sys(clk_sys),
	.rst(rst),
	.sck(sck),
	.ssN(ssN),
	.misoOut(misoOut),
	.misoOeN(misoOeN),
	.transferReadyOut(transferReadyOut),
	.transferReadyOeN(transferReadyOeN)
);

// ---- test/sksr_port_tb.sv ----
// Bench of the serial key port against a host model.
`timescale 1ns/10ps
module sksr_port_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic sck;
	logic ssN;
	logic mosi;
	logic misoOut;
	logic misoOeN;
	logic rdyOut;
	logic rdyOeN;
	logic [7:0] lastCommand;
	logic [7:0] r;
	int err_count = 0;
	int n_checks = 0;
	// Pull-up on the ready wire
	wire logic rdyWire = rdyOeN ? 1'b1 : rdyOut;

	always #4 clk_sys = ~clk_sys;

	// Byte gap limit sits above the 40 us host pacing, so fetches stay inside it
	sksr_port #(.RESET_LOW_CYC(200), .LONG_BUSY_CYC(300), .BYTE_TIMEOUT_CYC(6000)) u_dut (
		.clk_sys(clk_sys),
		.rst(rst),
		.sck(sck),
		.ssN(ssN),
		.mosi(mosi),
		.misoOut(misoOut),
		.misoOeN(misoOeN),
		.transferReadyIn(rdyWire),
		.transferReadyOut(rdyOut),
		.transferReadyOeN(rdyOeN),
		.sensorStatus(8'hE5),
		.firstKeyReport(8'h1F),
		.lastCommand(lastCommand)
	);

	sksr_host_model u_host (
		.clk_sys(clk_sys),
		.sck(sck),
		.ssN(ssN),
		.mosi(mosi),
		.miso(misoOut),
		.misoOeN(misoOeN),
		.rdy(rdyWire)
	);

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic x(input logic [7:0] tx);
		logic ok;
		u_host.xfer(tx, r, ok);
		check("pacing", {7'h00, ok}, 8'h01);
		if (!ok)
			finish_test();
	endtask

	function automatic logic [7:0] crc8(input logic [15:0] m);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	task automatic t_reset();
		int n;
		n = 0;
		while (rdyWire !== 1'b1 && n < 1000)
		begin
			@(negedge clk_sys);
			n++;
		end
		check("reset low", {7'h00, n >= 200 && n < 1000}, 8'h01);
		check("miso float", {7'h00, misoOeN}, 8'h01);
		if (n == 1000)
			finish_test();
	endtask

	task automatic t_resync(input logic [7:0] prev);
		x(8'h0F);
		x(8'h0F);
		check("echo", r, ~prev);
		x(8'h00);
		check("resync", r, 8'hF0);
	endtask

	task automatic t_unknown();
		x(8'h02);
		x(8'h06);
		x(8'h00);
		check("key err", r, 8'h5F);
	endtask

	task automatic t_status();
		x(8'h05);
		x(8'h06);
		check("status", r, 8'hA5);
		x(8'h00);
		check("crc", r, crc8({8'h05, 8'hA5}));
		check("ignored", lastCommand, 8'h05);
	endtask

	task automatic t_long(input logic [7:0] cmd, input logic [7:0] exp);
		x(cmd);
		x(8'h00);
		check("long cmd", r, exp);
	endtask

	// Pending answer must vanish after a long byte gap
	task automatic t_gap();
		x(8'h06);
		repeat (1500) @(negedge clk_sys);
		x(8'h00);
		check("gap drop", r, 8'h00);
	endtask

	initial
	begin
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		t_reset();
		t_resync(8'h00);
		t_unknown();
		t_resync(8'h06);
		t_status();
		t_long(8'h01, 8'hFE);
		t_long(8'h0E, 8'h00);
		t_gap();
		finish_test();
	end
endmodule // sksr_port_tb
